// file: rtl/disk_security_pkg.sv
// Constants and types for the disk security lock command block
package disk_security_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int PW_W   = 256;

  // Register port offsets
  localparam logic [2:0] ADDR_DATA       = 3'h0;
  localparam logic [2:0] ADDR_ERROR      = 3'h1;
  localparam logic [2:0] ADDR_SECURITY   = 3'h2;
  localparam logic [2:0] ADDR_STATUS_CMD = 3'h7;

  // Command codes
  localparam logic [7:0] CMD_SET_PASSWORD     = 8'hf1;
  localparam logic [7:0] CMD_UNLOCK           = 8'hf2;
  localparam logic [7:0] CMD_ERASE_PREPARE    = 8'hf3;
  localparam logic [7:0] CMD_ERASE_UNIT       = 8'hf4;
  localparam logic [7:0] CMD_FREEZE_LOCK      = 8'hf5;
  localparam logic [7:0] CMD_DISABLE_PASSWORD = 8'hf6;
  localparam logic [7:0] CMD_READ_DMA         = 8'hc8;
  localparam logic [7:0] CMD_WRITE_DMA        = 8'hca;
  localparam logic [7:0] CMD_READ_LONG        = 8'h22;
  localparam logic [7:0] CMD_WRITE_LONG       = 8'h32;
  localparam logic [7:0] CMD_READ_MULTIPLE    = 8'hc4;
  localparam logic [7:0] CMD_WRITE_MULTIPLE   = 8'hc5;
  localparam logic [7:0] CMD_READ_SECTORS     = 8'h20;
  localparam logic [7:0] CMD_WRITE_SECTORS    = 8'h30;
  localparam logic [7:0] CMD_WRITE_VERIFY     = 8'h3c;

  // Control word fields
  localparam int CTL_IDENT_BIT = 0;
  localparam int CTL_LEVEL_BIT = 8;

  // Error and status register bits
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_BUSY_BIT   = 7;
  localparam int ST_READY_BIT  = 6;
  localparam int ST_DRQ_BIT    = 3;
  localparam int ST_ERR_BIT    = 0;

  // Security state register fields
  localparam int SEC_LOCK_BIT       = 0;
  localparam int SEC_FREEZE_BIT     = 1;
  localparam int SEC_USER_VALID_BIT = 2;
  localparam int SEC_LEVEL_BIT      = 3;
  localparam int SEC_ARMED_BIT      = 4;
  localparam int SEC_COUNT_LSB      = 8;

  // Data block layout and counts
  localparam logic [2:0] UNLOCK_TRIES = 3'h5;
  localparam logic [2:0] COUNT_EMPTY  = 3'h0;
  localparam logic [7:0] CTL_WORD     = 8'h00;
  localparam logic [7:0] PW_LAST_WORD = 8'h10;
  localparam logic [7:0] LAST_WORD    = 8'hff;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'b00,
    PHASE_XFER = 2'b01,
    PHASE_EXEC = 2'b10
  } phase_e;

endpackage : disk_security_pkg

// file: rtl/disk_security_lock.sv
// Security lock command interpreter of the disk controller
`timescale 1ns/1ps
module disk_security_lock
  import disk_security_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              power_cycle_i,
  input  wire logic              hw_reset_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   erase_start_o,
  output logic                   locked_o,
  output logic                   frozen_o,
  output logic                   busy_o,
  output logic                   drq_o
);

  phase_e            phase;
  logic [7:0]        cur_cmd;
  logic [7:0]        word_cnt;
  logic [DATA_W-1:0] ctl_word;
  logic [PW_W-1:0]   pw_buf;
  logic [PW_W-1:0]   user_pw;
  logic [PW_W-1:0]   master_pw;
  logic              user_valid;
  logic              level_max;
  logic              lock_hold_state;
  logic              freeze_hold_state;
  logic              erase_armed;
  logic [2:0]        unlock_count;
  logic              abort_flag;

  logic              cmd_wr;
  logic              data_wr;
  logic              exec;
  logic              issue_abort;
  logic              needs_data;
  logic              exec_ok;
  logic              match_user;
  logic              match_master;
  logic              sel_master;
  logic [7:0]        cmd_code;
  logic [3:0]        pw_index;
  logic [7:0]        status_reg;
  logic [7:0]        error_reg;
  logic [DATA_W-1:0] security_reg;

  assign cmd_code = wdata_i[7:0];
  assign cmd_wr   = wr_i && (addr_i == ADDR_STATUS_CMD)
                    && (phase == PHASE_IDLE);
  assign data_wr  = wr_i && (addr_i == ADDR_DATA) && (phase == PHASE_XFER);
  assign exec     = (phase == PHASE_EXEC);
  assign pw_index = 4'(word_cnt - 8'h01);

  // Checks made when the command byte arrives
  always_comb
  begin
    issue_abort = 1'b0;
    needs_data  = 1'b0;
    case (cmd_code)
      CMD_SET_PASSWORD:
      begin
        issue_abort = lock_hold_state || freeze_hold_state;
        needs_data  = !issue_abort;
      end
      CMD_UNLOCK:
      begin
        issue_abort = freeze_hold_state
                      || (unlock_count == COUNT_EMPTY);
        needs_data  = !issue_abort;
      end
      CMD_ERASE_PREPARE:
        issue_abort = freeze_hold_state;
      CMD_ERASE_UNIT:
      begin
        issue_abort = freeze_hold_state
                      || !erase_armed
                      || (unlock_count == COUNT_EMPTY);
        needs_data  = !issue_abort;
      end
      CMD_FREEZE_LOCK:
        issue_abort = lock_hold_state;
      CMD_DISABLE_PASSWORD:
      begin
        issue_abort = lock_hold_state || freeze_hold_state;
        needs_data  = !issue_abort;
      end
      CMD_READ_DMA, CMD_WRITE_DMA, CMD_READ_LONG, CMD_WRITE_LONG,
      CMD_READ_MULTIPLE, CMD_WRITE_MULTIPLE, CMD_READ_SECTORS,
      CMD_WRITE_SECTORS, CMD_WRITE_VERIFY:
        issue_abort = lock_hold_state;
      default:
        issue_abort = 1'b0;
    endcase
  end

  // Password comparison against stored values
  assign sel_master   = ctl_word[CTL_IDENT_BIT];
  assign match_user   = user_valid && (pw_buf == user_pw);
  assign match_master = (pw_buf == master_pw);

  always_comb
  begin
    exec_ok = 1'b0;
    case (cur_cmd)
      CMD_ERASE_UNIT:
        exec_ok = sel_master ? match_master : match_user;
      CMD_UNLOCK:
        exec_ok = sel_master ? (!level_max && match_master)
                             : match_user;
      CMD_DISABLE_PASSWORD:
        exec_ok = sel_master ? match_master : match_user;
      CMD_SET_PASSWORD:
        exec_ok = 1'b1;
      default:
        exec_ok = 1'b0;
    endcase
  end

  // Command phase sequencer
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      phase <= PHASE_IDLE;
    else
      case (phase)
        PHASE_IDLE:
          if (cmd_wr && needs_data)
            phase <= PHASE_XFER;
        PHASE_XFER:
          if (data_wr && (word_cnt == LAST_WORD))
            phase <= PHASE_EXEC;
        PHASE_EXEC:
          phase <= PHASE_IDLE;
        default:
          phase <= PHASE_IDLE;
      endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      cur_cmd <= 8'h00;
    else if (cmd_wr)
      cur_cmd <= cmd_code;
  end

  // Data block capture; reserved words are counted and dropped
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      word_cnt <= CTL_WORD;
      ctl_word <= '0;
      pw_buf   <= '0;
    end
    else if (cmd_wr)
      word_cnt <= CTL_WORD;
    else if (data_wr)
    begin
      word_cnt <= word_cnt + 8'h01;
      if (word_cnt == CTL_WORD)
        ctl_word <= wdata_i;
      else if (word_cnt <= PW_LAST_WORD)
        pw_buf[{pw_index, 4'h0} +: DATA_W] <= wdata_i;
    end
  end

  // Stored passwords and level
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      user_pw    <= '0;
      master_pw  <= '0;
      user_valid <= 1'b0;
      level_max  <= 1'b0;
    end
    else if (exec && exec_ok)
      case (cur_cmd)
        CMD_SET_PASSWORD:
          if (sel_master)
            master_pw <= pw_buf;
          else
          begin
            user_pw    <= pw_buf;
            user_valid <= 1'b1;
            level_max  <= ctl_word[CTL_LEVEL_BIT];
          end
        CMD_ERASE_UNIT, CMD_DISABLE_PASSWORD:
          user_valid <= 1'b0;
        default:
          user_valid <= user_valid;
      endcase
  end

  // Lock state follows the user password only across a power cycle
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      lock_hold_state <= 1'b0;
    else if (power_cycle_i)
      lock_hold_state <= user_valid;
    else if (exec && exec_ok
             && ((cur_cmd == CMD_ERASE_UNIT) || (cur_cmd == CMD_UNLOCK)))
      lock_hold_state <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || power_cycle_i)
      freeze_hold_state <= 1'b0;
    else if (cmd_wr && (cmd_code == CMD_FREEZE_LOCK) && !issue_abort)
      freeze_hold_state <= 1'b1;
  end

  // Erase is armed only by the command directly before it
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || power_cycle_i)
      erase_armed <= 1'b0;
    else if (cmd_wr)
      erase_armed <= (cmd_code == CMD_ERASE_PREPARE) && !issue_abort;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i || power_cycle_i || hw_reset_i)
      unlock_count <= UNLOCK_TRIES;
    else if (exec && !exec_ok && (cur_cmd == CMD_UNLOCK)
             && lock_hold_state && (unlock_count != COUNT_EMPTY))
      unlock_count <= unlock_count - 3'h1;
  end

  // Abort reporting, cleared when a fresh command is accepted
  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      abort_flag <= 1'b0;
    else if (cmd_wr)
      abort_flag <= issue_abort;
    else if (exec)
      abort_flag <= !exec_ok;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      erase_start_o <= 1'b0;
    else
      erase_start_o <= exec && exec_ok && (cur_cmd == CMD_ERASE_UNIT);
  end

  // Register read port
  always_comb
  begin
    status_reg               = 8'h00;
    status_reg[ST_BUSY_BIT]  = exec;
    status_reg[ST_READY_BIT] = 1'b1;
    status_reg[ST_DRQ_BIT]   = (phase == PHASE_XFER);
    status_reg[ST_ERR_BIT]   = abort_flag;
    error_reg                = 8'h00;
    error_reg[ERR_ABORT_BIT] = abort_flag;
    security_reg                     = '0;
    security_reg[SEC_LOCK_BIT]       = lock_hold_state;
    security_reg[SEC_FREEZE_BIT]     = freeze_hold_state;
    security_reg[SEC_USER_VALID_BIT] = user_valid;
    security_reg[SEC_LEVEL_BIT]      = level_max;
    security_reg[SEC_ARMED_BIT]      = erase_armed;
    security_reg[SEC_COUNT_LSB +: 3] = unlock_count;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
      case (addr_i)
        ADDR_STATUS_CMD: rdata_o <= {8'h00, status_reg};
        ADDR_ERROR:      rdata_o <= {8'h00, error_reg};
        ADDR_SECURITY:   rdata_o <= security_reg;
        default:         rdata_o <= '0;
      endcase
    else
      rdata_o <= '0;
  end

  assign locked_o = lock_hold_state;
  assign frozen_o = freeze_hold_state;
  assign busy_o   = exec;
  assign drq_o    = (phase == PHASE_XFER);

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  erase_needs_prep_a: assert property (
    (cmd_wr && cmd_code == CMD_ERASE_UNIT && !erase_armed)
      |=> abort_flag && phase == PHASE_IDLE)
    else $error("erase accepted without prepare");

  erase_frozen_a: assert property (
    (cmd_wr && cmd_code == CMD_ERASE_UNIT && freeze_hold_state)
      |=> abort_flag && !drq_o)
    else $error("erase accepted while frozen");

  freeze_enter_a: assert property (
    (cmd_wr && cmd_code == CMD_FREEZE_LOCK && !lock_hold_state
     && !power_cycle_i) |=> freeze_hold_state && !abort_flag)
    else $error("freeze command did not freeze");

  frozen_blocks_a: assert property (
    (cmd_wr && freeze_hold_state && (cmd_code == CMD_SET_PASSWORD
     || cmd_code == CMD_UNLOCK || cmd_code == CMD_DISABLE_PASSWORD))
      |=> abort_flag && phase == PHASE_IDLE)
    else $error("lock change accepted while frozen");

  freeze_sticky_a: assert property (
    freeze_hold_state && !power_cycle_i |=> freeze_hold_state)
    else $error("freeze left without power cycle");

  freeze_locked_a: assert property (
    (cmd_wr && cmd_code == CMD_FREEZE_LOCK && lock_hold_state
     && !power_cycle_i) |=> abort_flag && !freeze_hold_state)
    else $error("freeze accepted while locked");

  medium_locked_a: assert property (
    (cmd_wr && lock_hold_state && (cmd_code == CMD_READ_DMA
     || cmd_code == CMD_WRITE_SECTORS || cmd_code == CMD_WRITE_VERIFY))
      |=> abort_flag)
    else $error("medium access accepted while locked");

  set_locked_a: assert property (
    (cmd_wr && cmd_code == CMD_SET_PASSWORD
     && (lock_hold_state || freeze_hold_state)) |=> abort_flag && !drq_o)
    else $error("set password accepted while locked");

  erase_result_a: assert property (
    erase_start_o |-> !user_valid && !lock_hold_state
                      && $stable(master_pw))
    else $error("erase left user password or lock");

  erase_wrong_a: assert property (
    (exec && cur_cmd == CMD_ERASE_UNIT && !exec_ok)
      |=> abort_flag && !erase_start_o && $stable(user_pw)
          && $stable(user_valid))
    else $error("wrong erase password changed state");

  master_level_a: assert property (
    (exec && cur_cmd == CMD_UNLOCK && sel_master && level_max)
      |=> abort_flag)
    else $error("master password unlocked at maximum level");

  master_no_lock_a: assert property (
    (exec && cur_cmd == CMD_SET_PASSWORD && sel_master)
      |=> $stable(user_valid) && master_pw == $past(pw_buf))
    else $error("master password set changed lock");

  count_floor_a: assert property (
    (cmd_wr && unlock_count == COUNT_EMPTY
     && (cmd_code == CMD_UNLOCK || cmd_code == CMD_ERASE_UNIT))
      |=> abort_flag ##1 phase == PHASE_IDLE)
    else $error("unlock or erase accepted at zero count");

  erase_disarm_a: assert property (
    (cmd_wr && cmd_code != CMD_ERASE_PREPARE && !power_cycle_i)
      |=> !erase_armed)
    else $error("erase still armed after another command");

  erase_seen_c: cover property (erase_start_o);
  freeze_seen_c: cover property (cmd_wr && cmd_code == CMD_FREEZE_LOCK
                                 && freeze_hold_state);
  unlock_ok_c: cover property (exec && cur_cmd == CMD_UNLOCK && exec_ok
                               && lock_hold_state);
  count_empty_c: cover property (unlock_count == COUNT_EMPTY);

endmodule : disk_security_lock

// file: testbench/disk_host_model.sv
// Host model issuing task-file commands and data blocks
`timescale 1ns/1ps
module disk_host_model
  import disk_security_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  input  wire logic              drq_i,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  output logic                   wr_o,
  output logic                   rd_o
);
  initial
  begin
    addr_o  = 3'h4;
    wdata_o = 16'h0000;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One strobe cycle; released address and data lines show inverted values, strobes go low
  task automatic access(input logic rd, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    @(posedge clock_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= ~rd;
    rd_o    <= rd;
    @(posedge clock_i);
    addr_o  <= ~a;
    wdata_o <= ~d;
    wr_o    <= 1'b0;
    rd_o    <= 1'b0;
    #1;
    q = rdata_i;
  endtask : access

  task automatic command(input logic [7:0] code);
    logic [DATA_W-1:0] q;
    access(1'b0, ADDR_STATUS_CMD, {8'h00, code}, q);
  endtask : command

  // Full block only when the device asks for data
  task automatic send_block(input logic [DATA_W-1:0] ctrl,
                            input logic [PW_W-1:0]   pw);
    logic [DATA_W-1:0] q;
    @(posedge clock_i);
    #1;
    if (drq_i !== 1'b1)
      return;
    access(1'b0, ADDR_DATA, ctrl, q);
    for (int i = 0; i < 16; i++)
      access(1'b0, ADDR_DATA, pw[16*i +: 16], q);
    repeat (239)
      access(1'b0, ADDR_DATA, 16'h0000, q);
  endtask : send_block
endmodule : disk_host_model

// file: testbench/tb_disk_security_lock.sv
// Self-checking testbench for the disk security lock block
`timescale 1ns/1ps
module tb_disk_security_lock import disk_security_pkg::*;;
  localparam logic [PW_W-1:0] USER_PW   = {8{32'h13579bdf}};
  localparam logic [PW_W-1:0] MASTER_PW = {8{32'h2468ace0}};
  localparam logic [PW_W-1:0] WRONG_PW  = {8{32'h0f0f1e1e}};

  logic              clock_i;
  logic              rst_n_i;
  logic              power_cycle_i;
  logic              hw_reset_i;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              erase_start;
  logic              locked;
  logic              frozen;
  logic              busy;
  logic              drq;
  logic [15:0]       erases = 16'h0000;
  int                bad_count = 0;
  int                total_checks = 0;
  logic [DATA_W-1:0] d;
  logic [7:0]        media [9];
  logic [7:0]        guarded [4];

  disk_security_lock i_dut (
    .clock_i       (clock_i),
    .rst_n_i       (rst_n_i),
    .power_cycle_i (power_cycle_i),
    .hw_reset_i    (hw_reset_i),
    .addr_i        (addr),
    .wdata_i       (wdata),
    .wr_i          (wr),
    .rd_i          (rd),
    .rdata_o       (rdata),
    .erase_start_o (erase_start),
    .locked_o      (locked),
    .frozen_o      (frozen),
    .busy_o        (busy),
    .drq_o         (drq)
  );

  disk_host_model i_host (
    .clock_i (clock_i),
    .rdata_i (rdata),
    .drq_i   (drq),
    .addr_o  (addr),
    .wdata_o (wdata),
    .wr_o    (wr),
    .rd_o    (rd)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
    if (erase_start === 1'b1)
      erases <= erases + 16'h0001;

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic pulse_in(input logic hw);
    @(posedge clock_i);
    hw_reset_i    <= hw;
    power_cycle_i <= ~hw;
    @(posedge clock_i);
    hw_reset_i    <= 1'b0;
    power_cycle_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask : pulse_in

  task automatic wait_idle;
    int n;
    n = 0;
    while ((busy !== 1'b0 || drq !== 1'b0) && n < 600)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    repeat (3) @(posedge clock_i);
  endtask : wait_idle

  task automatic cmd(input logic [7:0] code);
    i_host.command(code);
    wait_idle();
  endtask : cmd

  task automatic cmd_blk(input logic [7:0] code, input logic [15:0] ctrl,
                         input logic [PW_W-1:0] pw);
    i_host.command(code);
    i_host.send_block(ctrl, pw);
    wait_idle();
  endtask : cmd_blk

  task automatic expect_abort(input logic a);
    i_host.access(1'b1, ADDR_ERROR, 16'h0000, d);
    check(d, {13'h0000, a, 2'h0});
    i_host.access(1'b1, ADDR_STATUS_CMD, 16'h0000, d);
    check(d, {15'h0020, a});
  endtask : expect_abort

  task automatic state_is(input logic [15:0] exp, input logic [15:0] mask);
    i_host.access(1'b1, ADDR_SECURITY, 16'h0000, d);
    check(d & mask, exp);
  endtask : state_is

  initial
  begin
    rst_n_i       = 1'b0;
    power_cycle_i = 1'b0;
    hw_reset_i    = 1'b0;
    media = '{CMD_READ_DMA, CMD_WRITE_DMA, CMD_READ_LONG, CMD_WRITE_LONG,
              CMD_READ_MULTIPLE, CMD_WRITE_MULTIPLE, CMD_READ_SECTORS,
              CMD_WRITE_SECTORS, CMD_WRITE_VERIFY};
    guarded = '{CMD_SET_PASSWORD, CMD_UNLOCK, CMD_DISABLE_PASSWORD,
                CMD_ERASE_UNIT};
    repeat (5) @(posedge clock_i);
    rst_n_i <= 1'b1;
    state_is(16'h0500, 16'hffff);
    i_host.access(1'b1, 3'h3, 16'h0000, d);
    check(d, 16'h0000);
    expect_abort(1'b0);
    $display("Reset test done");
    cmd(CMD_ERASE_UNIT);
    expect_abort(1'b1);
    $display("Unprepared erase test done");
    i_host.command(CMD_SET_PASSWORD);
    check({15'h0000, drq}, 16'h0001);
    i_host.send_block(16'h0001, MASTER_PW);
    check({14'h0000, busy, drq}, 16'h0002);
    wait_idle();
    expect_abort(1'b0);
    state_is(16'h0500, 16'hffff);
    cmd_blk(CMD_SET_PASSWORD, 16'h0100, USER_PW);
    state_is(16'h050c, 16'hffff);
    check({15'h0000, locked}, 16'h0000);
    pulse_in(1'b0);
    check({15'h0000, locked}, 16'h0001);
    $display("Set password test done");
    foreach (media[i])
    begin
      cmd(media[i]);
      expect_abort(1'b1);
    end
    cmd(CMD_FREEZE_LOCK);
    expect_abort(1'b1);
    check({15'h0000, frozen}, 16'h0000);
    cmd_blk(CMD_SET_PASSWORD, 16'h0000, WRONG_PW);
    expect_abort(1'b1);
    cmd_blk(CMD_UNLOCK, 16'h0001, MASTER_PW);
    expect_abort(1'b1);
    check({15'h0000, locked}, 16'h0001);
    $display("Locked test done");
    cmd(CMD_ERASE_PREPARE);
    expect_abort(1'b0);
    cmd_blk(CMD_ERASE_UNIT, 16'h0000, WRONG_PW);
    expect_abort(1'b1);
    state_is(16'h000d, 16'h000f);
    check(erases, 16'h0000);
    cmd(CMD_ERASE_PREPARE);
    cmd_blk(CMD_ERASE_UNIT, 16'h0000, USER_PW);
    expect_abort(1'b0);
    check(erases, 16'h0001);
    state_is(16'h0000, 16'h0005);
    $display("Erase test done");
    cmd_blk(CMD_SET_PASSWORD, 16'h0000, USER_PW);
    pulse_in(1'b0);
    check({15'h0000, locked}, 16'h0001);
    cmd_blk(CMD_UNLOCK, 16'h0001, MASTER_PW);
    expect_abort(1'b0);
    check({15'h0000, locked}, 16'h0000);
    pulse_in(1'b0);
    repeat (5)
      cmd_blk(CMD_UNLOCK, 16'h0000, WRONG_PW);
    state_is(16'h0000, 16'h0700);
    cmd_blk(CMD_UNLOCK, 16'h0000, USER_PW);
    expect_abort(1'b1);
    cmd(CMD_ERASE_PREPARE);
    cmd_blk(CMD_ERASE_UNIT, 16'h0000, USER_PW);
    expect_abort(1'b1);
    check(erases, 16'h0001);
    pulse_in(1'b1);
    state_is(16'h0500, 16'h0700);
    cmd_blk(CMD_UNLOCK, 16'h0000, USER_PW);
    check({15'h0000, locked}, 16'h0000);
    $display("Unlock counter test done");
    cmd(CMD_ERASE_PREPARE);
    cmd(8'h90);
    cmd_blk(CMD_ERASE_UNIT, 16'h0000, USER_PW);
    expect_abort(1'b1);
    $display("Disarm test done");
    cmd(CMD_FREEZE_LOCK);
    expect_abort(1'b0);
    cmd(CMD_FREEZE_LOCK);
    expect_abort(1'b0);
    check({15'h0000, frozen}, 16'h0001);
    foreach (guarded[i])
    begin
      cmd_blk(guarded[i], 16'h0000, USER_PW);
      expect_abort(1'b1);
    end
    check(erases, 16'h0001);
    pulse_in(1'b0);
    check({15'h0000, frozen}, 16'h0000);
    $display("Freeze test done");
    give_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clock_i);
    bad_count++;
    $display("ERROR at %0t ns: watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_disk_security_lock
